// ==== hw/cfg_msg_pkg.sv ====
// package for the configuration message link: token codes, field widths, register map
// assumes both ends run on the same sys_clk and reset
package cfg_msg_pkg;
  localparam logic [7:0]  TOK_WRITE      = 8'hc0;   // start of a write request
  localparam logic [7:0]  TOK_READ       = 8'hc1;   // start of a read request
  localparam logic [7:0]  TOK_END        = 8'h01;   // closes every message
  localparam logic [7:0]  TOK_ACK        = 8'h03;   // success reply
  localparam logic [7:0]  TOK_NACK       = 8'h04;   // failure reply
  localparam int          REPLY_ID_BYTES = 3;
  localparam int          REG_NUM_BYTES  = 2;
  localparam int          DATA_BYTES     = 4;
  localparam logic [7:0]  NO_REPLY_CHAN  = 8'hff;   // low byte that suppresses a write reply
  localparam logic [15:0] CFG_PORT_SUFFIX = 16'hc20c; // destination suffix of the config resource
  localparam logic [7:0]  PS_RES_TYPE    = 8'h0c;   // processor-status resource type code
  localparam int          PS_RES_SHIFT   = 8;
  localparam int          NUM_CFG_REGS   = 8;       // implemented register numbers 0..7
  localparam logic [31:0] CFG_REG_RESET  = 32'h0000_0000;

  // build the resource identifier for a processor-status access
  function automatic logic [31:0] ps_resource_id(input logic [15:0] regNum);
    ps_resource_id = ({16'h0000, regNum} << PS_RES_SHIFT) | {24'h000000, PS_RES_TYPE};
  endfunction : ps_resource_id
endpackage : cfg_msg_pkg

// ==== hw/cfg_msg_if.sv ====
// byte-token link between a requester and the configuration responder
// assumes one clock; each direction is a valid/ready byte stream with a control flag
`timescale 1ns/100ps
interface cfg_msg_if (
  input wire logic sys_clk
);
  logic       reqValid;
  logic       reqReady;
  logic       reqCtrl;    // high: reqData is a control token
  logic [7:0] reqData;
  logic [23:0] reqDest;   // request channel-end destination (upper 24 bits)
  logic       rspValid;
  logic       rspReady;
  logic       rspCtrl;
  logic [7:0] rspData;
  logic [23:0] rspDest;   // reply destination taken from the request

  modport requester (output reqValid, reqCtrl, reqData, reqDest, rspReady,
                     input  reqReady, rspValid, rspCtrl, rspData, rspDest);
  modport responder (input  reqValid, reqCtrl, reqData, reqDest, rspReady,
                     output reqReady, rspValid, rspCtrl, rspData, rspDest);
endinterface : cfg_msg_if

// ==== hw/cfg_msg_responder.sv ====
// configuration responder: decodes read/write messages, accesses its register bank,
// and sends success or failure replies; also serves processor-status word accesses
// assumes the requester keeps its own framing; malformed messages are answered with failure
// Function
// (R1) write: start, reply id, regnum, data, end
// (R2) read: start, reply id, regnum, end
// (R3) write reply: success/fail token then end
// (R4) read reply: success, data, end; or fail
// (R5) requests carry 24-bit reply identifier
// (R6) reply id is node plus channel
// (R7) low byte all ones: write, no reply
// (R8) multi-byte fields sent most significant first
// (R9) requester addresses tile configuration destination
// (R10) status access moves one full word
// (R11) status id is regnum shifted, or 0x0c
// (R12) bad register or frame: fail, no change
`timescale 1ns/100ps
module cfg_msg_responder
  import cfg_msg_pkg::*;
#(
  parameter int NUM_REGS = NUM_CFG_REGS,
  parameter logic [15:0] TILE_ID = 16'h0000   // arbitrary tile identifier
) (
  input  wire logic        sys_clk,
  input  wire logic        reset,
  cfg_msg_if.responder     link,
  input  wire logic        psValid,     // processor-status access strobe
  input  wire logic        psWrite,
  input  wire logic [31:0] psResource,  // resource identifier
  input  wire logic [31:0] psWdata,
  output logic             psAck,
  output logic             psErr,
  output logic [31:0]      psRdata
);
  typedef enum {S_IDLE, S_ID, S_REG, S_DATA, S_END, S_DRAIN, S_RSP} state_t;

  state_t      state_reg;
  logic        isWrite_reg;
  logic        bad_reg;
  logic [23:0] replyId_reg;
  logic [15:0] regNum_reg;
  logic [31:0] data_reg;
  logic [2:0]  cnt_reg;
  logic [2:0]  rspIdx_reg;
  logic [2:0]  rspLen_reg;
  logic        rspOk_reg;
  logic [31:0] regs_reg [NUM_REGS];

  logic reqTake;
  logic rspTake;
  logic regHit;
  logic [7:0] psType;
  logic [15:0] psNum;

  assign reqTake = link.reqValid && link.reqReady;
  assign rspTake = link.rspValid && link.rspReady;
  assign regHit  = regNum_reg < 16'(NUM_REGS);
  assign link.reqReady = (state_reg != S_RSP);
  assign link.rspValid = (state_reg == S_RSP);
  assign link.rspDest  = replyId_reg;                           // [R6]

  // only messages on the configuration destination are decoded
  logic destOk;
  assign destOk = (link.reqDest == {TILE_ID, CFG_PORT_SUFFIX[15:8]}); // [R9]

  // receive state machine: each field shifts in most significant byte first
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_reg   <= S_IDLE;
      isWrite_reg <= 1'b0;
      bad_reg     <= 1'b0;
      replyId_reg <= 24'h000000;
      regNum_reg  <= 16'h0000;
      data_reg    <= 32'h0000_0000;
      cnt_reg     <= 3'h0;
      rspIdx_reg  <= 3'h0;
      rspLen_reg  <= 3'h0;
      rspOk_reg   <= 1'b0;
    end else begin
      case (state_reg)
        S_IDLE: begin
          if (reqTake && link.reqCtrl && destOk &&
              (link.reqData == TOK_WRITE || link.reqData == TOK_READ)) begin // [R1] [R2]
            isWrite_reg <= (link.reqData == TOK_WRITE);
            bad_reg     <= 1'b0;
            cnt_reg     <= 3'h0;
            state_reg   <= S_ID;
          end
        end
        S_ID: begin
          if (reqTake) begin
            if (link.reqCtrl) begin
              // an early end token has already closed the frame, so fail it at once
              bad_reg    <= 1'b1;                                    // [R12]
              rspOk_reg  <= 1'b0;
              rspIdx_reg <= 3'h0;
              rspLen_reg <= 3'h2;
              state_reg  <= (link.reqData == TOK_END) ? S_RSP : S_DRAIN;
            end else begin
              replyId_reg <= {replyId_reg[15:0], link.reqData};     // [R5] [R8]
              cnt_reg     <= cnt_reg + 3'h1;
              if (cnt_reg == 3'(REPLY_ID_BYTES - 1)) begin
                cnt_reg   <= 3'h0;
                state_reg <= S_REG;
              end
            end
          end
        end
        S_REG: begin
          if (reqTake) begin
            if (link.reqCtrl) begin
              // waiting for a second end token here would hang the link
              bad_reg    <= 1'b1;                                    // [R12]
              rspOk_reg  <= 1'b0;
              rspIdx_reg <= 3'h0;
              rspLen_reg <= 3'h2;
              state_reg  <= (link.reqData == TOK_END) ? S_RSP : S_DRAIN;
            end else begin
              regNum_reg <= {regNum_reg[7:0], link.reqData};        // [R8]
              cnt_reg    <= cnt_reg + 3'h1;
              if (cnt_reg == 3'(REG_NUM_BYTES - 1)) begin
                cnt_reg   <= 3'h0;
                state_reg <= isWrite_reg ? S_DATA : S_END;
              end
            end
          end
        end
        S_DATA: begin
          if (reqTake) begin
            if (link.reqCtrl) begin
              // short data field: answer failure, leave the bank alone
              bad_reg    <= 1'b1;                                    // [R12]
              rspOk_reg  <= 1'b0;
              rspIdx_reg <= 3'h0;
              rspLen_reg <= 3'h2;
              state_reg  <= (link.reqData == TOK_END) ? S_RSP : S_DRAIN;
            end else begin
              data_reg <= {data_reg[23:0], link.reqData};           // [R8]
              cnt_reg  <= cnt_reg + 3'h1;
              if (cnt_reg == 3'(DATA_BYTES - 1)) begin
                state_reg <= S_END;
              end
            end
          end
        end
        S_END: begin
          if (reqTake) begin
            if (link.reqCtrl && link.reqData == TOK_END) begin
              rspOk_reg  <= !bad_reg && regHit;                     // [R12]
              rspIdx_reg <= 3'h0;
              // success read carries four data bytes between tokens
              rspLen_reg <= (!isWrite_reg && !bad_reg && regHit) ? 3'h6 : 3'h2; // [R3] [R4]
              if (!isWrite_reg && !bad_reg && regHit) begin
                data_reg <= regs_reg[regNum_reg[$clog2(NUM_REGS)-1:0]];
              end
              // a suppressed write still happens, just never answered
              if (isWrite_reg && !bad_reg && replyId_reg[7:0] == NO_REPLY_CHAN) begin
                state_reg <= S_IDLE;                                // [R7]
              end else begin
                state_reg <= S_RSP;
              end
            end else begin
              bad_reg   <= 1'b1;                                     // [R12]
              state_reg <= S_DRAIN;
            end
          end
        end
        S_DRAIN: begin
          // swallow the rest of a broken frame, then fail it
          if (reqTake && link.reqCtrl && link.reqData == TOK_END) begin
            rspOk_reg  <= 1'b0;                                      // [R12]
            rspIdx_reg <= 3'h0;
            rspLen_reg <= 3'h2;
            state_reg  <= S_RSP;
          end
        end
        S_RSP: begin
          if (rspTake) begin
            rspIdx_reg <= rspIdx_reg + 3'h1;
            if (rspIdx_reg == rspLen_reg - 3'h1) begin
              state_reg <= S_IDLE;
            end
          end
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  // reply byte selection: token, optional data msb first, end token
  always_comb begin
    link.rspCtrl = 1'b1;
    link.rspData = rspOk_reg ? TOK_ACK : TOK_NACK;                  // [R3] [R4]
    if (rspIdx_reg == rspLen_reg - 3'h1) begin
      link.rspData = TOK_END;
    end else if (rspIdx_reg != 3'h0) begin
      link.rspCtrl = 1'b0;
      link.rspData = data_reg[8'(31 - 8 * (int'(rspIdx_reg) - 1)) -: 8]; // [R8]
    end
  end

  // processor-status decode: type code in low byte, number above it
  assign psType = psResource[7:0];
  assign psNum  = psResource[23:8];

  // register bank; a message write lands only when the frame closed cleanly on a mapped number, and wins over a status write in the same cycle
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        regs_reg[i] <= CFG_REG_RESET;
      end
    end else if (state_reg == S_END && reqTake && link.reqCtrl && link.reqData == TOK_END &&
                 isWrite_reg && !bad_reg && regHit) begin           // [R12] [R7]
      regs_reg[regNum_reg[$clog2(NUM_REGS)-1:0]] <= data_reg;
    end else if (psValid && psWrite && psType == PS_RES_TYPE &&
                 psNum < 16'(NUM_REGS)) begin                       // [R11]
      regs_reg[psNum[$clog2(NUM_REGS)-1:0]] <= psWdata;            // [R10]
    end
  end

  // status word answer, one cycle after the strobe
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      psAck   <= 1'b0;
      psErr   <= 1'b0;
      psRdata <= 32'h0000_0000;
    end else begin
      psAck <= psValid;
      psErr <= psValid && !(psType == PS_RES_TYPE && psNum < 16'(NUM_REGS)); // [R11]
      if (psValid && !psWrite && psType == PS_RES_TYPE && psNum < 16'(NUM_REGS)) begin
        psRdata <= regs_reg[psNum[$clog2(NUM_REGS)-1:0]];          // [R10]
      end
    end
  end
endmodule : cfg_msg_responder

// ==== hw/cfg_msg_requester.sv ====
// configuration requester: turns a user command into a framed message, collects the reply
// assumes the responder answers every request except a suppressed write
`timescale 1ns/100ps
module cfg_msg_requester
  import cfg_msg_pkg::*;
#(
  parameter logic [15:0] TARGET_TILE = 16'h0000   // arbitrary target tile identifier
) (
  input  wire logic        sys_clk,
  input  wire logic        reset,
  cfg_msg_if.requester     link,
  input  wire logic        cmdValid,
  output logic             cmdReady,
  input  wire logic        cmdWrite,
  input  wire logic [23:0] cmdReplyId,   // node id and channel number
  input  wire logic [15:0] cmdRegNum,
  input  wire logic [31:0] cmdWdata,
  output logic             doneValid,    // one-cycle pulse when the reply ends, or when the last byte of a suppressed write is sent
  output logic             doneOk,
  output logic [31:0]      doneRdata
);
  typedef enum {Q_IDLE, Q_SEND, Q_WAIT} state_t;

  state_t      state_reg;
  logic [79:0] frame_reg;   // start, id, regnum, data bytes msb first
  logic [3:0]  idx_reg;
  logic [3:0]  len_reg;
  logic        noReply_reg;
  logic        ok_reg;
  logic [31:0] rdata_reg;

  assign cmdReady      = (state_reg == Q_IDLE);
  assign link.reqValid = (state_reg == Q_SEND);
  assign link.reqDest  = {TARGET_TILE, CFG_PORT_SUFFIX[15:8]};      // [R9]
  assign link.rspReady = (state_reg == Q_WAIT);
  // first and last bytes are control tokens
  assign link.reqCtrl  = (idx_reg == 4'h0) || (idx_reg == len_reg - 4'h1);
  assign link.reqData  = (idx_reg == len_reg - 4'h1) ? TOK_END : frame_reg[79:72];

  // request framing and reply collection
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_reg   <= Q_IDLE;
      frame_reg   <= 80'h0;
      idx_reg     <= 4'h0;
      len_reg     <= 4'h0;
      noReply_reg <= 1'b0;
      ok_reg      <= 1'b0;
      rdata_reg   <= 32'h0000_0000;
      doneValid   <= 1'b0;
      doneOk      <= 1'b0;
      doneRdata   <= 32'h0000_0000;
    end else begin
      doneValid <= 1'b0;
      case (state_reg)
        Q_IDLE: begin
          if (cmdValid) begin
            frame_reg   <= {cmdWrite ? TOK_WRITE : TOK_READ, cmdReplyId, cmdRegNum,
                            cmdWdata};                              // [R1] [R2] [R5] [R6] [R8]
            len_reg     <= cmdWrite ? 4'hb : 4'h7;
            idx_reg     <= 4'h0;
            noReply_reg <= cmdWrite && cmdReplyId[7:0] == NO_REPLY_CHAN; // [R7]
            state_reg   <= Q_SEND;
          end
        end
        Q_SEND: begin
          if (link.reqReady) begin
            frame_reg <= {frame_reg[71:0], 8'h00};
            idx_reg   <= idx_reg + 4'h1;
            if (idx_reg == len_reg - 4'h1) begin
              if (noReply_reg) begin
                doneValid <= 1'b1;
                doneOk    <= 1'b1;
                state_reg <= Q_IDLE;
              end else begin
                state_reg <= Q_WAIT;
              end
            end
          end
        end
        Q_WAIT: begin
          if (link.rspValid) begin
            if (link.rspCtrl && link.rspData == TOK_END) begin
              doneValid <= 1'b1;
              doneOk    <= ok_reg;
              doneRdata <= rdata_reg;
              state_reg <= Q_IDLE;
            end else if (link.rspCtrl) begin
              ok_reg <= (link.rspData == TOK_ACK);                   // [R3] [R4]
            end else begin
              rdata_reg <= {rdata_reg[23:0], link.rspData};         // [R8]
            end
          end
        end
        default: state_reg <= Q_IDLE;
      endcase
    end
  end
endmodule : cfg_msg_requester

// ==== dv/cfg_msg_sva.sv ====
// checker for the configuration message link between requester and responder
// assumes its inputs are the signals of one cfg_msg_if instance
`timescale 1ns/100ps
module cfg_msg_sva
  import cfg_msg_pkg::*;
#(
  parameter logic [15:0] TILE_ID = 16'h0000
) (
  input wire logic        sys_clk,
  input wire logic        reset,
  input wire logic        reqValid,
  input wire logic        reqReady,
  input wire logic        reqCtrl,
  input wire logic [7:0]  reqData,
  input wire logic [23:0] reqDest,
  input wire logic        rspValid,
  input wire logic        rspReady,
  input wire logic        rspCtrl,
  input wire logic [7:0]  rspData,
  input wire logic [23:0] rspDest
);
  logic        reqBeat;
  logic        rspBeat;
  logic [3:0]  reqIdx_reg;
  logic [2:0]  rspIdx_reg;
  logic        isRead_reg;
  logic [23:0] id_reg;
  logic [7:0]  firstTok_reg;

  // a byte moves when both sides agree
  assign reqBeat = reqValid && reqReady;
  assign rspBeat = rspValid && rspReady;

  // request position, kind and reply id; reset to 0 on the closing token
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      reqIdx_reg <= 4'h0;
    end else if (reqBeat) begin
      if (reqCtrl && reqData == TOK_END && reqIdx_reg != 4'h0) begin
        reqIdx_reg <= 4'h0;
      end else begin
        reqIdx_reg <= reqIdx_reg + 4'h1;
      end
      if (reqIdx_reg == 4'h0) isRead_reg <= (reqData == TOK_READ);
      if (reqIdx_reg inside {4'h1, 4'h2, 4'h3}) id_reg <= {id_reg[15:0], reqData};
    end
  end

  // reply position and its first token
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rspIdx_reg <= 3'h0;
    end else if (rspBeat) begin
      rspIdx_reg <= (rspCtrl && rspData == TOK_END) ? 3'h0 : rspIdx_reg + 3'h1;
      if (rspIdx_reg == 3'h0) firstTok_reg <= rspData;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  sequence sReqEnd;
    reqBeat && reqCtrl && reqData == TOK_END && reqIdx_reg != 4'h0;
  endsequence
  sequence sRspStart;
    $rose(rspValid);
  endsequence

  a_start_to_cfg: assert property (
    reqBeat && reqCtrl && reqIdx_reg == 4'h0 |-> reqDest == {TILE_ID, 8'hc2})
    else $error("request start sent to a foreign destination");
  a_req_fields: assert property (
    reqBeat && reqIdx_reg != 4'h0 && reqIdx_reg < (isRead_reg ? 4'h6 : 4'ha) |-> !reqCtrl)
    else $error("token inside request fields");
  a_req_end_pos: assert property (
    reqBeat && reqIdx_reg == (isRead_reg ? 4'h6 : 4'ha) |-> reqCtrl && reqData == TOK_END)
    else $error("request not closed after its fields");
  a_reply_prompt: assert property (
    sReqEnd ##0 !(!isRead_reg && id_reg[7:0] == NO_REPLY_CHAN) |=> rspValid)
    else $error("reply did not start after request end");
  a_no_reply: assert property (
    sReqEnd ##0 (!isRead_reg && id_reg[7:0] == NO_REPLY_CHAN) |=> !rspValid [*4])
    else $error("reply sent for a suppressed write");
  a_first_token: assert property (
    sRspStart |-> rspCtrl && (rspData == TOK_ACK || rspData == TOK_NACK))
    else $error("reply does not open with success or failure");
  a_reply_dest: assert property (
    sRspStart |-> rspDest == id_reg)
    else $error("reply routed away from the requested id");
  a_read_data: assert property (
    rspBeat && rspIdx_reg != 3'h0 && rspIdx_reg < 3'h5 && firstTok_reg == TOK_ACK
    && isRead_reg |-> !rspCtrl)
    else $error("token inside read reply data");
  a_reply_end: assert property (
    rspBeat && rspIdx_reg == ((firstTok_reg == TOK_ACK && isRead_reg) ? 3'h5 : 3'h1)
    |-> rspCtrl && rspData == TOK_END)
    else $error("reply not closed at its length");
endmodule : cfg_msg_sva

// ==== dv/test_tile_config_message_access.sv ====
// self-checking bench: requester and responder joined by the link interface
// assumes a 50 ns sys_clk and a synchronous active-high reset
`timescale 1ns/100ps
module test_tile_config_message_access;
  import cfg_msg_pkg::*;
  localparam logic [15:0] TILE = 16'h002a;
  logic        sys_clk = 1'b0;
  logic        reset = 1'b1;
  logic        cmdValid = 1'b0;
  logic        cmdReady;
  logic        cmdWrite = 1'b0;
  logic [23:0] cmdReplyId = 24'h000000;
  logic [15:0] cmdRegNum = 16'h0000;
  logic [31:0] cmdWdata = 32'h00000000;
  logic        doneValid;
  logic        doneOk;
  logic [31:0] doneRdata;
  logic        psValid = 1'b0;
  logic        psWrite = 1'b0;
  logic [31:0] psResource = 32'h00000000;
  logic [31:0] psWdata = 32'h00000000;
  logic        psAck;
  logic        psErr;
  logic [31:0] psRdata;
  int          errors = 0;
  int          comparisons = 0;
  logic [7:0]  seen[$];

  cfg_msg_if cfg_msg_if_i (.sys_clk(sys_clk));
  cfg_msg_requester #(.TARGET_TILE(TILE)) cfg_msg_requester_i (
    .sys_clk(sys_clk), .reset(reset), .link(cfg_msg_if_i.requester),
    .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdWrite(cmdWrite),
    .cmdReplyId(cmdReplyId), .cmdRegNum(cmdRegNum), .cmdWdata(cmdWdata),
    .doneValid(doneValid), .doneOk(doneOk), .doneRdata(doneRdata));
  cfg_msg_responder #(.TILE_ID(TILE)) cfg_msg_responder_i (
    .sys_clk(sys_clk), .reset(reset), .link(cfg_msg_if_i.responder),
    .psValid(psValid), .psWrite(psWrite), .psResource(psResource),
    .psWdata(psWdata), .psAck(psAck), .psErr(psErr), .psRdata(psRdata));
  cfg_msg_sva #(.TILE_ID(TILE)) cfg_msg_sva_i (
    .sys_clk(sys_clk), .reset(reset),
    .reqValid(cfg_msg_if_i.reqValid), .reqReady(cfg_msg_if_i.reqReady),
    .reqCtrl(cfg_msg_if_i.reqCtrl), .reqData(cfg_msg_if_i.reqData),
    .reqDest(cfg_msg_if_i.reqDest), .rspValid(cfg_msg_if_i.rspValid),
    .rspReady(cfg_msg_if_i.rspReady), .rspCtrl(cfg_msg_if_i.rspCtrl),
    .rspData(cfg_msg_if_i.rspData), .rspDest(cfg_msg_if_i.rspDest));

  // 20 MHz clock
  always #25 sys_clk = ~sys_clk;

  // record every request byte as it crosses the wire
  always @(posedge sys_clk) begin
    if (cfg_msg_if_i.reqValid && cfg_msg_if_i.reqReady) seen.push_back(cfg_msg_if_i.reqData);
  end

  task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic tally_and_finish;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : tally_and_finish

  // a used-up bound is a mismatch and ends the run
  task automatic give_up(input int n, input int lim);
    if (n >= lim) begin
      errors++;
      tally_and_finish();
    end
  endtask : give_up

  // one message command; also compares the bytes seen on the wire
  task automatic do_msg(input logic wr, input logic [23:0] id, input logic [15:0] rn,
                        input logic [31:0] wd, input logic expOk, input logic [31:0] expRd);
    int n;
    logic [7:0] want[$];
    seen.delete();
    cmdValid = 1'b1;
    cmdWrite = wr;
    cmdReplyId = id;
    cmdRegNum = rn;
    cmdWdata = wd;
    for (n = 0; n < 60 && cmdReady !== 1'b1; n++) begin @(posedge sys_clk); #1; end
    give_up(n, 60);
    @(posedge sys_clk);
    #1;
    cmdValid = 1'b0;
    for (n = 0; n < 60 && doneValid !== 1'b1; n++) begin @(posedge sys_clk); #1; end
    give_up(n, 60);
    check("reply ok", {31'h0, doneOk}, {31'h0, expOk});
    if (!wr && expOk) check("read data", doneRdata, expRd);
    want.push_back(wr ? TOK_WRITE : TOK_READ);
    for (n = 2; n >= 0; n--) want.push_back(id[8*n +: 8]);
    for (n = 1; n >= 0; n--) want.push_back(rn[8*n +: 8]);
    if (wr) for (n = 3; n >= 0; n--) want.push_back(wd[8*n +: 8]);
    want.push_back(TOK_END);
    check("request length", 32'(seen.size()), 32'(want.size()));
    for (n = 0; n < want.size(); n++) begin
      check("request byte", {24'h0, seen[n]}, {24'h0, want[n]});
    end
  endtask : do_msg

  // one processor-status access
  task automatic do_ps(input logic wr, input logic [31:0] res, input logic [31:0] wd,
                       input logic expErr, input logic [31:0] expRd);
    int n;
    psValid = 1'b1;
    psWrite = wr;
    psResource = res;
    psWdata = wd;
    @(posedge sys_clk);
    #1;
    psValid = 1'b0;
    for (n = 0; n < 8 && psAck !== 1'b1; n++) begin @(posedge sys_clk); #1; end
    give_up(n, 8);
    check("status error", {31'h0, psErr}, {31'h0, expErr});
    if (!wr && !expErr) check("status read", psRdata, expRd);
    // let an edge pass so that the next strobe is a fresh one
    @(posedge sys_clk);
    #1;
  endtask : do_ps

  // main sequence: reset, message accesses, refusals, status accesses
  initial begin
    int i;
    repeat (16) @(posedge sys_clk);
    #1;
    reset = 1'b0;
    do_msg(1'b0, 24'h001205, 16'h0000, 32'h0, 1'b1, CFG_REG_RESET);
    for (i = 0; i < NUM_CFG_REGS; i++) begin
      do_msg(1'b1, 24'h00ab07, 16'(i), 32'ha5000000 | 32'(i), 1'b1, 32'h0);
    end
    for (i = 0; i < NUM_CFG_REGS; i++) begin
      do_msg(1'b0, 24'h00ab07, 16'(i), 32'h0, 1'b1, 32'ha5000000 | 32'(i));
    end
    do_msg(1'b1, 24'h001205, 16'h0103, 32'hdeadbeef, 1'b0, 32'h0);
    do_msg(1'b0, 24'h001205, 16'h0008, 32'h0, 1'b0, 32'h0);
    do_msg(1'b0, 24'h001205, 16'h0003, 32'h0, 1'b1, 32'ha5000003);
    do_msg(1'b1, 24'h0012ff, 16'h0005, 32'h0badf00d, 1'b1, 32'h0);
    do_msg(1'b0, 24'h001205, 16'h0005, 32'h0, 1'b1, 32'h0badf00d);
    do_ps(1'b0, 32'h0000050c, 32'h0, 1'b0, 32'h0badf00d);
    do_ps(1'b1, 32'h0000060c, 32'hcafe0006, 1'b0, 32'h0);
    do_msg(1'b0, 24'h001205, 16'h0006, 32'h0, 1'b1, 32'hcafe0006);
    do_ps(1'b1, 32'h0000060d, 32'h1, 1'b1, 32'h0);
    do_ps(1'b1, 32'h0000080c, 32'h1, 1'b1, 32'h0);
    do_ps(1'b0, 32'h0000060c, 32'h0, 1'b0, 32'hcafe0006);
    tally_and_finish();
  end
endmodule : test_tile_config_message_access
